/* logic/wwdt_pkg.sv */
// Package of register map, field positions, reset values and timing counts for the windowed watchdog.
package wwdt_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [3:0] ADDR_MODE     = 4'h0;
  localparam logic [3:0] ADDR_TIMEOUT  = 4'h1;
  localparam logic [3:0] ADDR_FEED     = 4'h2;
  localparam logic [3:0] ADDR_COUNTER  = 4'h3;
  localparam logic [3:0] ADDR_WARNING  = 4'h4;
  localparam logic [3:0] ADDR_WINDOW   = 4'h5;
  localparam logic [3:0] ADDR_STATUS   = 4'h6;
  // ==========================================================================
  // Mode register fields
  localparam int MODE_RUN_BIT     = 0;
  localparam int MODE_RESET_BIT   = 1;
  localparam int MODE_PROTECT_BIT = 2;
  // ==========================================================================
  // Status register fields
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_WARNING_BIT = 1;
  // ==========================================================================
  // Reset values and constants
  localparam logic [23:0] TIMEOUT_RESET = 24'hffffff;
  localparam logic [23:0] WINDOW_RESET  = 24'hffffff;
  localparam logic [9:0]  WARNING_RESET = 10'h000;
  localparam logic [23:0] TIMEOUT_FLOOR = 24'h0000ff;
  localparam logic [7:0]  FEED_WORD_ONE = 8'haa;
  localparam logic [7:0]  FEED_WORD_TWO = 8'h55;
  // ==========================================================================
  // Timing: watchdog tick clock and prescaler
  localparam int          MCLK_HZ        = 100_000_000;
  localparam int          TICK_CLOCK_HZ  = 1_000_000;
  localparam int          TICK_DIV_COUNT = MCLK_HZ / TICK_CLOCK_HZ;
  localparam logic [1:0]  PRESCALE_LAST  = 2'h3;
endpackage

/* logic/wwdt_tick_div.sv */
// Divider that makes the watchdog tick clock enable and the four-period counter step.
`timescale 1ns/1ps
module wwdt_tick_div (
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  input  wire logic run_in,
  output logic      tick_out,
  output logic      step_out
);
  // ==========================================================================
  // Tick clock divider
  logic [6:0] div_r;
  logic [1:0] pre_r;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      div_r    <= 7'h00;
      tick_out <= 1'b0;
    end else if (div_r == 7'(wwdt_pkg::TICK_DIV_COUNT - 1)) begin
      div_r    <= 7'h00;
      tick_out <= 1'b1;
    end else begin
      div_r    <= div_r + 7'h01;
      tick_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Prescaler by four
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pre_r    <= 2'h0;
      step_out <= 1'b0;
    end else begin
      step_out <= 1'b0;
      if (tick_out && run_in) begin
        pre_r <= pre_r + 2'h1;
        if (pre_r == wwdt_pkg::PRESCALE_LAST) begin
          step_out <= 1'b1; // [RULE5]
        end
      end
    end
  end
endmodule

/* logic/wwdt_core.sv */
// Windowed watchdog timer with register port, feed sequence, window, warning and protect.
`timescale 1ns/1ps
// Behaviour
// [RULE1] Run enable is write-once; once set and fed, zero writes are ignored.
// [RULE2] Warning raised on the tick after counter is no longer above compare.
// [RULE3] Each completed feed loads the timeout constant into the counter.
// [RULE4] Timeout constant writes below 0xff store 0xff instead.
// [RULE5] Counter steps once per four watchdog tick periods.
// [RULE6] Protect mode: early timeout change resets and sets timeout flag.
// [RULE7] Without protect, timeout constant writes accepted anytime, no side effect.
// [RULE8] Feed completed while counter exceeds window is a watchdog event.
// [RULE9] Window value 0xffffff allows every feed.
// [RULE10] Chip reset on timeout only when reset-on-timeout is set.
// [RULE11] Software must feed before the counter reaches timeout.
// [RULE12] Timeout flag is set on timeout and held until cleared.
// [RULE13] Warning flag is set when counter falls below warning compare; the code also sets it when counter equals compare.
// [RULE14] Warning compare of zero yields no warning at all.
// [RULE15] Feed is two fixed words in order; only then reload.
// [RULE16] Counter is 24-bit down counter, timeout at zero.
// [RULE17] Feed words 0xaa then 0x55; other writes abort the sequence.
// [RULE18] Status flags clear on write of one; zero leaves them.
module wwdt_core (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic             chip_reset_out,
  output logic             warn_irq_out,
  output logic             running_out
);
  // ==========================================================================
  // State
  typedef enum logic [0:0] {
    WWDT_FEED_IDLE  = 1'b0,
    WWDT_FEED_ARMED = 1'b1
  } wwdt_feed_t;

  logic [23:0] counter_value_r;
  logic [23:0] timeout_constant_r;
  logic [23:0] feed_window_limit_r;
  logic [9:0]  warning_compare_r;
  logic        run_enable_bit_r;
  logic        reset_on_timeout_r;
  logic        protect_mode_r;
  logic        fed_r;
  logic        timeout_flag_r;
  logic        warning_flag_r;
  wwdt_feed_t  feed_r;
  logic        tick;
  logic        step;
  logic        feed_done;
  logic        early_feed;
  logic        protect_hit;
  logic        timeout_hit;
  logic        wd_event;
  logic        below_warn;

  function automatic logic wr_at(input logic [3:0] a);
    wr_at = wr_in && (addr_in == a);
  endfunction

  wwdt_tick_div u_div (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .run_in   (running_out),
    .tick_out (tick),
    .step_out (step)
  );

  // ==========================================================================
  // Feed sequence
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      feed_r <= WWDT_FEED_IDLE;
    end else if (wr_in) begin
      case (feed_r)
        WWDT_FEED_IDLE: begin
          if (wr_at(wwdt_pkg::ADDR_FEED) && wdata_in[7:0] == wwdt_pkg::FEED_WORD_ONE) begin
            feed_r <= WWDT_FEED_ARMED; // [RULE15]
          end
        end
        WWDT_FEED_ARMED: begin
          feed_r <= WWDT_FEED_IDLE; // [RULE17]
        end
        default: begin
          feed_r <= WWDT_FEED_IDLE;
        end
      endcase
    end
  end

  // One combinational process, so that the strobe and address read inside wr_at wake it.
  // A continuous assign would only wake on the function's arguments and could miss a strobe.
  always_comb begin
    feed_done   = (feed_r == WWDT_FEED_ARMED) && wr_at(wwdt_pkg::ADDR_FEED)
                  && wdata_in[7:0] == wwdt_pkg::FEED_WORD_TWO; // [RULE17]
    early_feed  = feed_done && running_out && (counter_value_r > feed_window_limit_r); // [RULE8] [RULE9]
    protect_hit = protect_mode_r && running_out && wr_at(wwdt_pkg::ADDR_TIMEOUT)
                  && !(counter_value_r < {14'h0000, warning_compare_r}
                       && counter_value_r < feed_window_limit_r); // [RULE6] [RULE7]
    timeout_hit = step && running_out && (counter_value_r == 24'h000000); // [RULE16]
    wd_event    = early_feed || protect_hit || timeout_hit;
    below_warn  = counter_value_r <= {14'h0000, warning_compare_r};
  end

  // ==========================================================================
  // Mode bits
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      run_enable_bit_r   <= 1'b0;
      reset_on_timeout_r <= 1'b0;
      protect_mode_r     <= 1'b0;
      fed_r              <= 1'b0;
    end else begin
      if (wr_at(wwdt_pkg::ADDR_MODE)) begin
        run_enable_bit_r   <= run_enable_bit_r | wdata_in[wwdt_pkg::MODE_RUN_BIT]; // [RULE1]
        reset_on_timeout_r <= wdata_in[wwdt_pkg::MODE_RESET_BIT];
        protect_mode_r     <= wdata_in[wwdt_pkg::MODE_PROTECT_BIT];
      end
      if (feed_done && run_enable_bit_r) begin
        fed_r <= 1'b1; // [RULE1]
      end
    end
  end

  // ==========================================================================
  // Timeout constant, window and warning compare
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      timeout_constant_r  <= wwdt_pkg::TIMEOUT_RESET;
      feed_window_limit_r <= wwdt_pkg::WINDOW_RESET;
      warning_compare_r   <= wwdt_pkg::WARNING_RESET;
    end else begin
      if (wr_at(wwdt_pkg::ADDR_TIMEOUT)) begin
        if (wdata_in[23:0] < wwdt_pkg::TIMEOUT_FLOOR) begin
          timeout_constant_r <= wwdt_pkg::TIMEOUT_FLOOR; // [RULE4]
        end else begin
          timeout_constant_r <= wdata_in[23:0]; // [RULE7]
        end
      end
      if (wr_at(wwdt_pkg::ADDR_WINDOW)) begin
        feed_window_limit_r <= wdata_in[23:0];
      end
      if (wr_at(wwdt_pkg::ADDR_WARNING)) begin
        warning_compare_r <= wdata_in[9:0];
      end
    end
  end

  // ==========================================================================
  // Counter
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      counter_value_r <= wwdt_pkg::TIMEOUT_RESET;
    end else if (feed_done) begin
      counter_value_r <= timeout_constant_r; // [RULE3]
    end else if (step && running_out && counter_value_r != 24'h000000) begin
      counter_value_r <= counter_value_r - 24'h000001; // [RULE16]
    end
  end

  // ==========================================================================
  // Flags, interrupt and reset; a set in the same cycle as a clear wins.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      timeout_flag_r <= 1'b0;
      warning_flag_r <= 1'b0;
      warn_irq_out   <= 1'b0;
      chip_reset_out <= 1'b0;
      running_out    <= 1'b0;
    end else begin
      running_out <= run_enable_bit_r && (fed_r || feed_done);
      if (wd_event) begin
        timeout_flag_r <= 1'b1; // [RULE12]
      end else if (wr_at(wwdt_pkg::ADDR_STATUS) && wdata_in[wwdt_pkg::STAT_TIMEOUT_BIT]) begin
        timeout_flag_r <= 1'b0; // [RULE18]
      end
      // Compare sampled on the tick edge, so the warning trails the counter by one tick.
      if (tick && running_out && below_warn && warning_compare_r != 10'h000) begin
        warning_flag_r <= 1'b1; // [RULE2] [RULE13] [RULE14]
      end else if (wr_at(wwdt_pkg::ADDR_STATUS) && wdata_in[wwdt_pkg::STAT_WARNING_BIT]) begin
        warning_flag_r <= 1'b0; // [RULE18]
      end
      warn_irq_out <= warning_flag_r;
      // A reset pulse is held one cycle; the chip reset is expected to clear the block.
      chip_reset_out <= wd_event && reset_on_timeout_r; // [RULE10]
    end
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        wwdt_pkg::ADDR_MODE:    rdata_out <= {29'h0, protect_mode_r, reset_on_timeout_r, run_enable_bit_r};
        wwdt_pkg::ADDR_TIMEOUT: rdata_out <= {8'h00, timeout_constant_r};
        wwdt_pkg::ADDR_COUNTER: rdata_out <= {8'h00, counter_value_r};
        wwdt_pkg::ADDR_WARNING: rdata_out <= {22'h0, warning_compare_r};
        wwdt_pkg::ADDR_WINDOW:  rdata_out <= {8'h00, feed_window_limit_r};
        wwdt_pkg::ADDR_STATUS:  rdata_out <= {30'h0, warning_flag_r, timeout_flag_r};
        default:                rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_feed_two;
    feed_done;
  endsequence
  sequence s_word_one;
    feed_r == WWDT_FEED_IDLE && wr_in && addr_in == wwdt_pkg::ADDR_FEED
      && wdata_in[7:0] == wwdt_pkg::FEED_WORD_ONE;
  endsequence
  sequence s_word_two;
    feed_r == WWDT_FEED_ARMED && wr_in && addr_in == wwdt_pkg::ADDR_FEED
      && wdata_in[7:0] == wwdt_pkg::FEED_WORD_TWO;
  endsequence
  sequence s_foreign_write;
    feed_r == WWDT_FEED_ARMED && wr_in
      && !(addr_in == wwdt_pkg::ADDR_FEED && wdata_in[7:0] == wwdt_pkg::FEED_WORD_TWO);
  endsequence

  a_feed_reload: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE3]
    s_feed_two |=> counter_value_r == $past(timeout_constant_r))
    else $error("Feed did not reload counter.");
  a_run_sticky: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE1]
    run_enable_bit_r |=> run_enable_bit_r)
    else $error("Run enable cleared.");
  a_tc_floor: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE4]
    timeout_constant_r >= wwdt_pkg::TIMEOUT_FLOOR)
    else $error("Timeout constant below floor.");
  a_early_feed: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE8]
    early_feed |=> timeout_flag_r)
    else $error("Early feed not flagged.");
  a_window_off: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE9]
    feed_window_limit_r == 24'hffffff |-> !early_feed)
    else $error("Open window refused a feed.");
  a_reset_gate: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE10]
    chip_reset_out |-> $past(reset_on_timeout_r) && $past(wd_event))
    else $error("Reset without enable.");
  a_no_warn_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE14]
    warning_compare_r == 10'h000 && !warning_flag_r |=> !warning_flag_r)
    else $error("Warning with zero compare.");
  a_timeout_set: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE12]
    timeout_hit |=> timeout_flag_r)
    else $error("Timeout flag not set.");
  a_unprot_tc: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE7]
    !protect_mode_r && !early_feed && !timeout_hit |-> !wd_event)
    else $error("Unprotected write raised event.");

  // ==========================================================================
  // Feed sequence checks
  a_feed_arm: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE15]
    s_word_one |=> feed_r == WWDT_FEED_ARMED)
    else $error("First feed word did not arm.");
  a_feed_pair: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE15]
    s_word_one ##[1:4] s_word_two |=> counter_value_r == $past(timeout_constant_r))
    else $error("Feed pair did not reload counter.");
  a_feed_abort: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE17]
    s_foreign_write |=> feed_r == WWDT_FEED_IDLE)
    else $error("Foreign write did not abort feed.");
  a_late_feed: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE8]
    feed_done && counter_value_r <= feed_window_limit_r && !timeout_hit |-> !wd_event)
    else $error("Feed inside window raised event.");

  // ==========================================================================
  // Counter, flag and mode checks
  // A full timeout lies beyond a short run, so the counter end points are guarded here.
  a_step_gate: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE5]
    !feed_done && !step |=> counter_value_r == $past(counter_value_r))
    else $error("Counter moved without a step.");
  a_count_down: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE16]
    step && running_out && counter_value_r != 24'h000000 && !feed_done
      |=> counter_value_r == $past(counter_value_r) - 24'h000001)
    else $error("Counter did not count down.");
  a_hold_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE16]
    counter_value_r == 24'h000000 && !feed_done |=> counter_value_r == 24'h000000)
    else $error("Counter left zero without a feed.");
  a_floor_load: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE4]
    wr_in && addr_in == wwdt_pkg::ADDR_TIMEOUT && wdata_in[23:0] < wwdt_pkg::TIMEOUT_FLOOR
      |=> timeout_constant_r == wwdt_pkg::TIMEOUT_FLOOR)
    else $error("Small timeout constant not raised to floor.");
  a_tc_load: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE7]
    !protect_mode_r && wr_in && addr_in == wwdt_pkg::ADDR_TIMEOUT && wdata_in[23:0] >= wwdt_pkg::TIMEOUT_FLOOR
      |=> timeout_constant_r == $past(wdata_in[23:0]))
    else $error("Timeout constant not stored.");
  a_warn_set: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE13]
    tick && running_out && below_warn && warning_compare_r != 10'h000 |=> warning_flag_r)
    else $error("Warning flag not set.");
  a_warn_irq: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE2]
    warning_flag_r |=> warn_irq_out)
    else $error("Warning interrupt not raised.");
  a_flag_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE18]
    wr_in && addr_in == wwdt_pkg::ADDR_STATUS && wdata_in[wwdt_pkg::STAT_TIMEOUT_BIT] && !wd_event
      |=> !timeout_flag_r)
    else $error("Timeout flag not cleared.");
  a_event_flag: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE12]
    wd_event |=> timeout_flag_r)
    else $error("Watchdog event not flagged.");
  a_prot_hit: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE6]
    protect_hit |=> timeout_flag_r && chip_reset_out == $past(reset_on_timeout_r))
    else $error("Protected write not punished.");
  a_no_reset: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE10]
    !reset_on_timeout_r |=> !chip_reset_out)
    else $error("Chip reset with reset disabled.");
  a_run_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE1]
    running_out |=> running_out)
    else $error("Running watchdog stopped.");
endmodule

/* tb/wwdt_tb.sv */
// Self-checking register-level testbench for the windowed watchdog core.
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Signals and design
  logic        mclk_in;
  logic        nrst_in;
  logic [3:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        chip_reset_out;
  logic        warn_irq_out;
  logic        running_out;
  logic [31:0] got;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  int          pulses = 0;

  wwdt_core uut (
    .mclk_in        (mclk_in),
    .nrst_in        (nrst_in),
    .addr_in        (addr_in),
    .wdata_in       (wdata_in),
    .wr_in          (wr_in),
    .rd_in          (rd_in),
    .rdata_out      (rdata_out),
    .chip_reset_out (chip_reset_out),
    .warn_irq_out   (warn_irq_out),
    .running_out    (running_out)
  );

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Reset pulses last one cycle, so they are counted here rather than sampled by the tests.
  always @(posedge mclk_in) begin
    cycles++;
    if (chip_reset_out === 1'b1) pulses++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Access and compare tasks
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1;
    got = rdata_out;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk32(got, e);
  endtask

  task automatic feed();
    wr(wwdt_pkg::ADDR_FEED, 32'h000000aa);
    wr(wwdt_pkg::ADDR_FEED, 32'h00000055);
  endtask

  // ==========================================================================
  // Test sequence
  logic [31:0] rst_exp [8] = '{32'h0, 32'hffffff, 32'h0, 32'hffffff, 32'h0, 32'hffffff, 32'h0, 32'h0};

  initial begin
    nrst_in  = 1'b0;
    addr_in  = 4'h0;
    wdata_in = 32'h0;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    repeat (4) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i != 2) rd_chk(i[3:0], rst_exp[i]);
    end
    wr(wwdt_pkg::ADDR_TIMEOUT, 32'h10);
    rd_chk(wwdt_pkg::ADDR_TIMEOUT, 32'hff);
    wr(wwdt_pkg::ADDR_TIMEOUT, 32'h1234);
    rd_chk(wwdt_pkg::ADDR_TIMEOUT, 32'h1234);
    wr(wwdt_pkg::ADDR_TIMEOUT, 32'hff);
    wr(wwdt_pkg::ADDR_MODE, 32'h3);
    feed();
    rd_chk(wwdt_pkg::ADDR_COUNTER, 32'hff);
    wr(wwdt_pkg::ADDR_MODE, 32'h2);
    chk1(running_out, 1'b1);
    rd_chk(wwdt_pkg::ADDR_MODE, 32'h3);
    repeat (850) @(posedge mclk_in);
    rd(wwdt_pkg::ADDR_COUNTER);
    chk1(got === 32'hfd || got === 32'hfc, 1'b1);
    chk1(warn_irq_out, 1'b0);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h0);
    chk32(pulses, 0);
    // A foreign write between the two feed words must leave the count where it was.
    wr(wwdt_pkg::ADDR_FEED, 32'h000000aa);
    wr(wwdt_pkg::ADDR_STATUS, 32'h0);
    wr(wwdt_pkg::ADDR_FEED, 32'h00000055);
    rd(wwdt_pkg::ADDR_COUNTER);
    chk32(got, 32'hfd);
    feed();
    rd_chk(wwdt_pkg::ADDR_COUNTER, 32'hff);
    wr(wwdt_pkg::ADDR_TIMEOUT, 32'h300);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h0);
    chk32(pulses, 0);
    wr(wwdt_pkg::ADDR_TIMEOUT, 32'hff);
    wr(wwdt_pkg::ADDR_WINDOW, 32'h80);
    feed();
    repeat (2) @(posedge mclk_in);
    chk32(pulses, 1);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h1);
    wr(wwdt_pkg::ADDR_STATUS, 32'h0);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h1);
    wr(wwdt_pkg::ADDR_STATUS, 32'h1);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h0);
    wr(wwdt_pkg::ADDR_MODE, 32'h1);
    feed();
    repeat (2) @(posedge mclk_in);
    chk32(pulses, 1);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h1);
    wr(wwdt_pkg::ADDR_STATUS, 32'h1);
    wr(wwdt_pkg::ADDR_WINDOW, 32'hffffff);
    wr(wwdt_pkg::ADDR_MODE, 32'h7);
    wr(wwdt_pkg::ADDR_TIMEOUT, 32'h100);
    repeat (2) @(posedge mclk_in);
    chk32(pulses, 2);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h1);
    wr(wwdt_pkg::ADDR_STATUS, 32'h1);
    wr(wwdt_pkg::ADDR_WARNING, 32'h3ff);
    feed();
    repeat (250) @(posedge mclk_in);
    chk1(warn_irq_out, 1'b1);
    rd_chk(wwdt_pkg::ADDR_STATUS, 32'h2);
    chk32(pulses, 2);
    give_verdict();
  end
endmodule
